// ---- rtl/pegr_pkg.sv ----
// Shared types and constants of the pre-echo gain refiner
package pegr_pkg;
    localparam int              NSF        = 8;
    localparam int              EW         = 32;
    localparam int              GW         = 16;
    localparam int              SW         = 16;
    localparam int              SSB_MAX    = 64;
    localparam logic [3:0]      NSF_IDX    = 4'h8;
    localparam logic [6:0]      NSSF_8K    = 7'h04;
    localparam logic [6:0]      NSSF_STD   = 7'h08;
    localparam logic [3:0]      SSH_8K     = 4'h2;
    localparam logic [3:0]      SSH_STD    = 4'h3;
    localparam logic [5:0]      TH1_SHIFT  = 6'h03;
    localparam logic [7:0]      PEAK_DIV   = 8'h50;
    localparam logic [5:0]      SUM_SHIFT  = 6'h02;
    localparam logic [4:0]      LEVELS_NB  = 5'h14;
    localparam logic [4:0]      LEVELS_STD = 5'h04;
    localparam logic [4:0]      HB_NUM     = 5'h0f;
    localparam logic [4:0]      HB_DEN     = 5'h02;
    localparam logic [GW-1:0]   UNITY_GAIN = 16'h8000;
    localparam int              GAIN_FRAC  = 15;

    typedef enum logic [3:0] {
        PEGR_IDLE  = 4'h1,
        PEGR_LOAD  = 4'h2,
        PEGR_SCAN  = 4'h4,
        PEGR_APPLY = 4'h8
    } pegr_state_e;

    typedef struct packed {
        logic [3:0]                  firstNonEchoIndex;
        logic                        rate8k;
        logic                        narrowband;
        logic                        zcrAboveLimit;
        logic [9:0]                  subLen;
        logic [EW-1:0]               peakSubBlockEnergy;
        logic [EW-1:0]               previousFrameMeanEnergy;
        logic [EW-1:0]               critFloor;
        logic [NSF:0][EW-1:0]        energy;
        logic [NSF-1:0][EW-1:0]      highEnergy;
        logic [NSF-1:0][GW-1:0]      lowGain;
        logic [NSF-1:0][GW-1:0]      highBandGain;
    } pegr_frame_s;

    typedef struct packed {
        logic signed [SW-1:0] low;
        logic signed [SW-1:0] high;
    } pegr_pair_s;
endpackage : pegr_pkg

// ---- rtl/pegr_fifo.sv ----
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module pegr_fifo #(
    parameter int W = 32,
    parameter int D = 8
) (
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic         inValid,
    output logic              inReady,
    input  wire logic [W-1:0] inData,
    output logic              outValid,
    input  wire logic         outReady,
    output logic [W-1:0]      outData
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         cnt;
    } fifo_s;
    fifo_s fifo_r;
    fifo_s fifo_nxt;
    logic  push;
    logic  pop;

    always_comb begin
        inReady  = fifo_r.cnt != (AW+1)'(D);
        outValid = fifo_r.cnt != '0;
        outData  = fifo_r.mem[fifo_r.rp];
        push     = inValid && inReady;
        pop      = outValid && outReady;
        fifo_nxt = fifo_r;
        if (push) begin
            fifo_nxt.mem[fifo_r.wp] = inData;
            fifo_nxt.wp = (fifo_r.wp == AW'(D-1)) ? '0 : fifo_r.wp + 1'b1;
        end
        if (pop) begin
            fifo_nxt.rp = (fifo_r.rp == AW'(D-1)) ? '0 : fifo_r.rp + 1'b1;
        end
        if (push && !pop) begin
            fifo_nxt.cnt = fifo_r.cnt + 1'b1;
        end else if (pop && !push) begin
            fifo_nxt.cnt = fifo_r.cnt - 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            fifo_r <= '0;
        end else begin
            fifo_r <= fifo_nxt;
        end
    end
endmodule : pegr_fifo
`default_nettype wire

// ---- rtl/pegr_refiner.sv ----
// Pre-echo onset refinement, regression check, smoothing and band sum
`timescale 1ns/1ns
`default_nettype none
module pegr_refiner #(
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic                  core_clk,
    input  wire logic                  rst_n,
    input  wire logic                  frameValid,
    output logic                       frameReady,
    input  wire pegr_pkg::pegr_frame_s frame,
    input  wire logic                  ssbValid,
    output logic                       ssbReady,
    input  wire logic [31:0]           subSubBlockEnergy,
    input  wire logic                  inValid,
    output logic                       inReady,
    input  wire pegr_pkg::pegr_pair_s  inData,
    output logic                       outValid,
    input  wire logic                  outReady,
    output logic signed [17:0]         outData,
    output logic [15:0]                onsetPos,
    output logic                       inhibit
);
    import pegr_pkg::*;

    typedef struct packed {
        pegr_state_e                  st;
        pegr_frame_s                  fr;
        logic [SSB_MAX-1:0][EW-1:0]   ssb;
        logic [6:0]                   cnt;
        logic [EW-1:0]                ssbMax;
        logic [41:0]                  sum;
        logic [15:0]                  onset;
        logic [3:0]                   sub;
        logic [9:0]                   inSub;
        logic [15:0]                  n;
        logic [GW-1:0]                stairLow;
        logic [GW-1:0]                lastLow;
        logic [GW-1:0]                lastHigh;
        logic [GW-1:0]                rampOld;
        logic [GW-1:0]                rampNew;
        logic [4:0]                   rampK;
        logic                         outValid;
        logic signed [17:0]           outData;
        logic                         inhibit;
    } st_s;

    st_s                 st_r;
    st_s                 st_nxt;
    logic                fifoValid;
    logic                fifoReady;
    pegr_pair_s          fifoData;
    logic [3:0]          idx;
    logic [6:0]          nssf;
    logic [3:0]          ssh;
    logic [9:0]          lssf;
    logic [6:0]          numSsf;
    logic [4:0]          levels;
    logic [EW-1:0]       mcrit;
    logic [EW-1:0]       floorE;
    logic [EW-1:0]       baseE;
    logic [EW-1:0]       e;
    logic                below1;
    logic                below2;
    logic                veto;
    logic signed [40:0]  hbDiff;
    logic signed [40:0]  hbSum;
    logic [15:0]         onsetEff;
    logic [GW-1:0]       movedLow;
    logic [GW-1:0]       movedHigh;
    logic [GW-1:0]       lowSt;
    logic [GW-1:0]       highSt;
    logic [GW-1:0]       gLow;
    logic [2:0]          postIdx;
    logic signed [33:0]  acc;

    // Weighted step between two gains, divisor is levels plus one
    function automatic logic [GW-1:0] ramp(
        input logic [GW-1:0] oldG,
        input logic [GW-1:0] newG,
        input logic [4:0]    k,
        input logic [4:0]    lv
    );
        logic [21:0] num;
        num = 22'(5'(lv + 5'h01 - k) * oldG) + 22'(k * newG);
        return GW'(num / 22'(lv + 5'h01));
    endfunction : ramp

    // Zero-extending widening of an energy into a signed value
    function automatic logic signed [40:0] sx(input logic [EW-1:0] v);
        return $signed({9'h000, v});
    endfunction : sx

    pegr_fifo #(
        .W (2*SW),
        .D (FIFO_DEPTH)
    ) u_fifo (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .inValid  (inValid),
        .inReady  (inReady),
        .inData   (inData),
        .outValid (fifoValid),
        .outReady (fifoReady),
        .outData  (fifoData)
    );

    always_comb begin
        idx    = st_r.fr.firstNonEchoIndex;
        nssf   = st_r.fr.rate8k ? NSSF_8K : NSSF_STD;
        ssh    = st_r.fr.rate8k ? SSH_8K : SSH_STD;
        lssf   = st_r.fr.subLen >> ssh;
        // Memory onset looks at one sub-block only
        if (idx == 4'h0 || idx >= NSF_IDX) begin
            numSsf = nssf;
        end else begin
            numSsf = 7'((NSF_IDX - idx) * nssf);
        end
        levels = st_r.fr.narrowband ? LEVELS_NB : LEVELS_STD;

        // Compares use products instead of divisions to stay exact
        mcrit = st_r.fr.critFloor;
        if (40'(st_r.fr.peakSubBlockEnergy) > 40'(PEAK_DIV) * 40'(mcrit)
            && st_r.fr.zcrAboveLimit) begin
            mcrit = EW'(st_r.fr.peakSubBlockEnergy / EW'(PEAK_DIV));
        end
        if (idx == 4'h0) begin
            floorE = st_r.fr.previousFrameMeanEnergy;
            baseE  = st_r.fr.previousFrameMeanEnergy;
        end else begin
            floorE = mcrit;
            baseE  = st_r.fr.energy[4'(idx - 4'h1)];
        end
        e      = st_r.ssb[st_r.cnt[5:0]];
        below1 = (40'(e) << TH1_SHIFT) < 40'(st_r.ssbMax);
        below2 = e < floorE;
        if (st_r.cnt != 7'h00
            && 42'(e) * 42'(st_r.cnt + 7'h01)
               < 42'(baseE) + (st_r.sum << SUM_SHIFT)) begin
            below2 = 1'b1;
        end

        // False detection check, thresholds zero except high band 2/15 of the three-band sum
        veto = 1'b0;
        hbDiff = '0;
        hbSum  = '0;
        if (idx == 4'h2) begin
            veto = st_r.fr.highEnergy[1] < st_r.fr.highEnergy[0];
        end else if (idx >= 4'h3) begin
            hbDiff = sx(st_r.fr.highEnergy[3'(idx - 4'h1)])
                   - sx(st_r.fr.highEnergy[3'(idx - 4'h3)]);
            hbSum  = sx(st_r.fr.highEnergy[3'(idx - 4'h1)])
                   + sx(st_r.fr.highEnergy[3'(idx - 4'h2)])
                   + sx(st_r.fr.highEnergy[3'(idx - 4'h3)]);
            veto = st_r.fr.energy[idx - 4'h1]
                   < st_r.fr.energy[idx - 4'h3];
            if (hbDiff * $signed({36'h0, HB_NUM})
                < hbSum * $signed({36'h0, HB_DEN})) begin
                veto = 1'b1;
            end
        end // Onsets in sub-block zero or one are never vetoed

        // Stair gains for the current sample
        movedLow  = (idx == 4'h0) ? st_r.lastLow
                  : st_r.fr.lowGain[3'(idx - 4'h1)];
        movedHigh = (idx == 4'h0) ? st_r.lastHigh
                  : st_r.fr.highBandGain[3'(idx - 4'h1)];
        if (idx >= NSF_IDX) begin
            onsetEff = 16'hffff;
        end else if (st_r.onset > 16'(levels)) begin
            onsetEff = st_r.onset - 16'(levels);
        end else begin
            onsetEff = 16'h0000;
        end
        postIdx = (st_r.sub < idx) ? idx[2:0] : st_r.sub[2:0];
        if (st_r.inhibit) begin
            lowSt  = UNITY_GAIN;
            highSt = UNITY_GAIN;
        end else begin
            if (st_r.n < onsetEff) begin
                lowSt = (st_r.sub < idx) ? st_r.fr.lowGain[st_r.sub[2:0]]
                      : movedLow;
            end else begin
                lowSt = st_r.fr.lowGain[postIdx];
            end
            if (st_r.n < st_r.onset) begin
                highSt = (st_r.sub < idx)
                       ? st_r.fr.highBandGain[st_r.sub[2:0]]
                       : movedHigh;
            end else begin
                highSt = st_r.fr.highBandGain[postIdx];
            end
        end

        st_nxt     = st_r;
        frameReady = st_r.st == PEGR_IDLE;
        ssbReady   = st_r.st == PEGR_LOAD;
        fifoReady  = 1'b0;
        gLow       = lowSt;
        acc        = '0;
        if (st_r.outValid && outReady) begin
            st_nxt.outValid = 1'b0;
        end

        case (st_r.st)
            PEGR_IDLE: begin
                if (frameValid) begin
                    st_nxt.fr     = frame;
                    st_nxt.cnt    = '0;
                    st_nxt.ssbMax = '0;
                    st_nxt.sum    = '0;
                    st_nxt.st     = PEGR_LOAD;
                end
            end
            PEGR_LOAD: begin
                if (ssbValid) begin
                    st_nxt.ssb[st_r.cnt[5:0]] = subSubBlockEnergy;
                    if (subSubBlockEnergy > st_r.ssbMax) begin
                        st_nxt.ssbMax = subSubBlockEnergy;
                    end
                    if (st_r.cnt == numSsf - 7'h01) begin
                        st_nxt.cnt = '0;
                        st_nxt.st  = PEGR_SCAN;
                    end else begin
                        st_nxt.cnt = st_r.cnt + 7'h01;
                    end
                end
            end
            PEGR_SCAN: begin
                // Stops at the first sub-sub-block at or above a threshold
                if (st_r.cnt < numSsf && below1 && below2) begin
                    st_nxt.sum = st_r.sum + 42'(e);
                    st_nxt.cnt = st_r.cnt + 7'h01;
                end else begin
                    st_nxt.onset = 16'(idx * st_r.fr.subLen)
                                 + 16'(st_r.cnt * lssf);
                    st_nxt.inhibit  = veto;
                    st_nxt.n        = '0;
                    st_nxt.sub      = '0;
                    st_nxt.inSub    = '0;
                    st_nxt.rampK    = '0;
                    st_nxt.stairLow = st_r.lastLow;
                    st_nxt.st       = PEGR_APPLY;
                end
            end
            PEGR_APPLY: begin
                fifoReady = !st_r.outValid || outReady;
                if (fifoValid && fifoReady) begin
                    if (lowSt != st_r.stairLow) begin
                        st_nxt.rampOld = st_r.stairLow;
                        st_nxt.rampNew = lowSt;
                        st_nxt.rampK   = 5'h01;
                        gLow = ramp(st_r.stairLow, lowSt, 5'h01, levels);
                    end else if (st_r.rampK != 5'h00 && st_r.rampK < levels) begin
                        st_nxt.rampK = st_r.rampK + 5'h01;
                        gLow = ramp(st_r.rampOld, st_r.rampNew,
                                    st_r.rampK + 5'h01, levels);
                    end else begin
                        st_nxt.rampK = 5'h00;
                    end
                    st_nxt.stairLow = lowSt;
                    acc = 34'($signed({1'b0, gLow}) * fifoData.low)
                        + 34'($signed({1'b0, highSt}) * fifoData.high);
                    st_nxt.outData  = acc[GAIN_FRAC+17:GAIN_FRAC];
                    st_nxt.outValid = 1'b1;
                    st_nxt.n        = st_r.n + 16'h0001;
                    if (st_r.inSub == st_r.fr.subLen - 10'h001) begin
                        st_nxt.inSub = '0;
                        st_nxt.sub   = st_r.sub + 4'h1;
                        if (st_r.sub == NSF_IDX - 4'h1) begin
                            // Gains carried into the next frame
                            st_nxt.lastLow  = lowSt;
                            st_nxt.lastHigh = highSt;
                            st_nxt.st       = PEGR_IDLE;
                        end
                    end else begin
                        st_nxt.inSub = st_r.inSub + 10'h001;
                    end
                end
            end
            default: begin
                st_nxt.st = PEGR_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_r          <= '0;
            st_r.st       <= PEGR_IDLE;
            st_r.lastLow  <= UNITY_GAIN;
            st_r.lastHigh <= UNITY_GAIN;
            st_r.stairLow <= UNITY_GAIN;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign outValid = st_r.outValid;
    assign outData  = st_r.outData;
    assign onsetPos = st_r.onset;
    assign inhibit  = st_r.inhibit;
endmodule : pegr_refiner
`default_nettype wire

// ---- testbench/pegr_refiner_monitor.sv ----
// Protocol checker for the refiner ports
`timescale 1ns/1ns
`default_nettype none
module pegr_refiner_monitor (
    input wire logic               core_clk,
    input wire logic               rst_n,
    input wire logic               frameValid,
    input wire logic               frameReady,
    input wire logic               ssbReady,
    input wire logic               outValid,
    input wire logic               outReady,
    input wire logic signed [17:0] outData,
    input wire logic [15:0]        onsetPos,
    input wire logic               inhibit
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_out_hold_data: assert property (
        outValid && !outReady |=> outValid && $stable(outData))
        else $error("stalled output changed");
    a_ready_exclusive: assert property (!(frameReady && ssbReady))
        else $error("frame and energy ports ready together");
    a_frame_opens_load: assert property (
        frameValid && frameReady |=> ssbReady && !frameReady)
        else $error("taken frame did not open energy load");
    a_load_needs_frame: assert property (
        $rose(ssbReady) |-> $past(frameValid && frameReady))
        else $error("energy load opened without a frame");
    a_load_end_busy: assert property ($fell(ssbReady) |-> !frameReady [*2])
        else $error("frame port reopened right after load");
    a_out_in_apply: assert property (
        $rose(outValid) |-> $past(!frameReady && !ssbReady))
        else $error("output produced outside apply");
    a_onset_at_scan: assert property (
        $changed(onsetPos) || $changed(inhibit) |-> !frameReady && !ssbReady)
        else $error("onset or inhibit moved outside scan exit");
    // Reset must clear outputs, so this one is not disabled by it
    a_reset_clear: assert property (disable iff (1'b0)
        !rst_n |=> !outValid && outData == 18'h0 && onsetPos == 16'h0
        && !inhibit)
        else $error("outputs not cleared by reset");

    c_frame_taken: cover property (frameValid && frameReady);
    c_inhibit_set: cover property ($rose(inhibit));
    c_out_stall: cover property (outValid && !outReady);
endmodule : pegr_refiner_monitor

bind pegr_refiner pegr_refiner_monitor i_pegr_refiner_monitor (
    .core_clk(core_clk), .rst_n(rst_n), .frameValid(frameValid),
    .frameReady(frameReady), .ssbReady(ssbReady), .outValid(outValid),
    .outReady(outReady), .outData(outData), .onsetPos(onsetPos),
    .inhibit(inhibit));
`default_nettype wire

// ---- testbench/pegr_stream_model.sv ----
// Sample source upstream and stalling sink downstream
`timescale 1ns/1ns
`default_nettype none
module pegr_stream_model #(
    parameter int CNT = 64
) (
    input  wire logic           core_clk,
    input  wire logic           start,
    input  wire logic           inReady,
    output var  logic           inValid,
    output var  pegr_pkg::pegr_pair_s inData,
    output var  logic           outReady
);
    import pegr_pkg::*;
    int   n   = CNT;
    int   k   = 0;
    logic acc = 1'b0;
    initial inValid = 1'b0;
    always @(posedge core_clk) acc <= inValid && inReady;
    // Idle data toggles so a stale pair can never look valid
    always @(negedge core_clk) begin
        if (start) n = 0;
        else if (acc) n = n + 1;
        inValid  <= !start && n < CNT;
        inData   <= (n < CNT) ? {16'(n * 37 - 1000), 16'(500 - n * 11)}
                              : {16'(k * 5), 16'(~k)};
        outReady <= (k % 3) != 0;
        k = k + 1;
    end
endmodule : pegr_stream_model
`default_nettype wire

// ---- testbench/pegr_refiner_tb.sv ----
// Self-checking bench of the pre-echo gain refiner
`timescale 1ns/1ns
`default_nettype none
module pegr_refiner_tb;
    import pegr_pkg::*;
    logic               core_clk          = 1'b0;
    logic               rst_n             = 1'b0;
    logic               frameValid        = 1'b0;
    logic               ssbValid          = 1'b0;
    logic               start             = 1'b0;
    logic [31:0]        subSubBlockEnergy = 32'h0;
    pegr_frame_s        frame             = '0;
    pegr_frame_s        f;
    pegr_pair_s         inData;
    logic               frameReady, ssbReady, inValid, inReady;
    logic               outValid, outReady, inhibit;
    logic signed [17:0] outData;
    logic [15:0]        onsetPos;
    int                 errorCnt = 0;
    int                 nChecks  = 0;
    int                 outCnt   = 0;
    longint             gOld, gNew, gHi, lv;

    pegr_refiner i_pegr_refiner (.core_clk(core_clk), .rst_n(rst_n),
        .frameValid(frameValid), .frameReady(frameReady), .frame(frame),
        .ssbValid(ssbValid), .ssbReady(ssbReady),
        .subSubBlockEnergy(subSubBlockEnergy), .inValid(inValid),
        .inReady(inReady), .inData(inData), .outValid(outValid),
        .outReady(outReady), .outData(outData), .onsetPos(onsetPos),
        .inhibit(inhibit));
    pegr_stream_model i_pegr_stream_model (.core_clk(core_clk),
        .start(start), .inReady(inReady), .inValid(inValid),
        .inData(inData), .outReady(outReady));

    initial forever #2 core_clk = ~core_clk;

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        nChecks++;
        if (seen !== exp) begin
            errorCnt++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic close_out;
        if (errorCnt == 0 && nChecks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out

    // Ramp over lv samples from the boundary, truncating like the design
    function automatic logic [31:0] expOut(input int n);
        longint gl;
        gl = (n < lv) ? ((lv - n) * gOld + (n + 1) * gNew) / (lv + 1) : gNew;
        return 32'((gl * (n * 37 - 1000) + gHi * (500 - n * 11)) >>> 15);
    endfunction : expOut

    always @(posedge core_clk) begin
        if (rst_n && outValid === 1'b1 && outReady === 1'b1) begin
            chk("outData", 32'(outData), expOut(outCnt));
            outCnt++;
        end
    end

    // Rising energies; high band quadratic so no slope test trips
    task automatic base(input int idx, input logic r8, input logic z);
        f = '0;
        f.firstNonEchoIndex = 4'(idx);
        f.rate8k = r8;
        f.zcrAboveLimit = z;
        f.subLen = 10'h008;
        f.peakSubBlockEnergy = 32'h00013880;
        for (int i = 0; i < 9; i++) f.energy[i] = 32'(100000 + i * 1000);
        for (int i = 0; i < 8; i++) begin
            f.highEnergy[i] = 32'(1000 * i * i);
            f.lowGain[i] = UNITY_GAIN;
            f.highBandGain[i] = UNITY_GAIN;
        end
        gOld = 32768;
        gNew = 32768;
        gHi = 32768;
        lv = 4;
    endtask : base

    // Energy 0 sits below the raised floor; the rest stop the delay
    task automatic run_frame(input int nE, input int onExp,
                             input logic inhExp);
        outCnt = 0;
        frame = f;
        frameValid = 1'b1;
        start <= 1'b1;
        do @(posedge core_clk); while (frameReady !== 1'b1);
        @(negedge core_clk);
        frameValid = 1'b0;
        start <= 1'b0;
        for (int j = 0; j < nE; j++) begin
            subSubBlockEnergy = (j == 0) ? 32'h000001f4 : 32'h00001388;
            ssbValid = 1'b1;
            do @(posedge core_clk); while (ssbReady !== 1'b1);
            @(negedge core_clk);
        end
        ssbValid = 1'b0;
        if (nE > 16) chk("inReady", 32'(inReady), 32'h0);
        while (outCnt < 64) @(posedge core_clk);
        @(negedge core_clk);
        chk("onsetPos", 32'(onsetPos), 32'(onExp));
        chk("inhibit", 32'(inhibit), 32'(inhExp));
    endtask : run_frame

    task automatic t_onset_refine;
        base(3, 1'b0, 1'b1);
        run_frame(40, 25, 1'b0);
        base(3, 1'b0, 1'b0);
        run_frame(40, 24, 1'b0);
        base(3, 1'b1, 1'b1);
        run_frame(20, 26, 1'b0);
        base(8, 1'b0, 1'b1);
        run_frame(8, 65, 1'b0);
    endtask : t_onset_refine

    task automatic t_regression;
        base(2, 1'b0, 1'b1);
        f.highEnergy[0] = 32'h000007d0;
        run_frame(48, 17, 1'b1);
        base(4, 1'b0, 1'b1);
        f.energy[3] = 32'h0000c350;
        run_frame(32, 33, 1'b1);
        base(4, 1'b0, 1'b1);
        f.highEnergy[3] = 32'h0000044c;
        run_frame(32, 33, 1'b1);
        base(1, 1'b0, 1'b1);
        f.highEnergy[0] = 32'h000007d0;
        run_frame(56, 9, 1'b0);
    endtask : t_regression

    task automatic t_smoothing;
        base(0, 1'b0, 1'b1);
        for (int i = 0; i < 8; i++) begin
            f.lowGain[i] = 16'h4000;
            f.highBandGain[i] = 16'h2000;
        end
        gNew = 16384;
        gHi = 8192;
        run_frame(8, 0, 1'b0);
        base(0, 1'b0, 1'b1);
        f.narrowband = 1'b1;
        gOld = 16384;
        lv = 20;
        run_frame(8, 0, 1'b0);
    endtask : t_smoothing

    initial begin
        repeat (20) @(negedge core_clk);
        rst_n = 1'b1;
        t_onset_refine;
        t_regression;
        t_smoothing;
        close_out;
    end

    // Ten frames need under 2500 cycles; eight times that is a hang
    initial begin
        repeat (20000) @(posedge core_clk);
        errorCnt++;
        close_out;
    end
endmodule : pegr_refiner_tb
`default_nettype wire
